// ==== rtl/vdtc_regs.sv ====
// vdtc_regs: control register bank and the timing values it steers.
// assumes a same-clock register port; video timing strobes are pins and are synchronised.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module vdtc_regs
	import vdtc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic [1:0]  video_std_i,
	input  wire logic        line_start_i,
	input  wire logic        field_boundary_i,
	input  wire logic        std_line_count_i,
	input  wire logic        odd_line_count_i,
	input  wire logic        field_bt656_i,
	input  wire logic        vbit_bt656_i,
	input  wire logic        genlock_bit_i,
	input  wire logic        genlock_serial_out_select_i,
	output logic             field_bit_o,
	output logic             vert_bit_o,
	output logic             rtc_mode_o,
	output logic             rtc_submode_o,
	output logic             general_purpose_pin_o,
	output logic signed [9:0] active_video_window_stop_o,
	output logic signed [10:0] hsync_shift_o,
	output logic      [8:0]  hblank_to_hsync_delay_o,
	output logic      [8:0]  hblank_length_o,
	output logic signed [7:0] vblank_start_adj_o,
	output logic signed [7:0] vblank_stop_adj_o,
	output logic             color_pll_reset_o,
	output logic      [1:0]  auto_chroma_gain_o,
	output logic      [2:0]  comb_primary_o,
	output logic             comb_adaptive_o,
	output logic             comb_fallback_none_o,
	output logic      [10:0] chroma_bw_khz_o
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage is read only by the second
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] pins_w;
	assign pins_w = {line_start_i, field_boundary_i, std_line_count_i,
	                 odd_line_count_i, field_bt656_i, vbit_bt656_i};
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
		end
	end
	logic line_s, fb_s, std_s, odd_s, f656_s, v656_s;
	assign {line_s, fb_s, std_s, odd_s, f656_s, v656_s} = sync2_q;
	logic gl_s1_q, gl_s2_q, sel_s1_q, sel_s2_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gl_s1_q  <= 1'b0;
			gl_s2_q  <= 1'b0;
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
		end else begin
			gl_s1_q  <= genlock_bit_i;
			gl_s2_q  <= gl_s1_q;
			sel_s1_q <= genlock_serial_out_select_i;
			sel_s2_q <= sel_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register bank
	logic [7:0] stop_up_q, stop_up_d;
	logic [9:0] stop_q, stop_d;
	logic [7:0] gl_q, gl_d, hs_q, hs_d, vbs_q, vbs_d, vbe_q, vbe_d;
	logic [7:0] c1_q, c1_d, c2_q, c2_d, rdata_q, rdata_d;
	logic       pll_rst_q, pll_rst_d, glpend_q, glpend_d;

	always_comb begin
		stop_up_d = stop_up_q;
		stop_d    = stop_q;
		gl_d      = gl_q;
		hs_d      = hs_q;
		vbs_d     = vbs_q;
		vbe_d     = vbe_q;
		c1_d      = c1_q;
		c2_d      = c2_q;
		pll_rst_d = 1'b0;
		glpend_d  = glpend_q;
		rdata_d   = 8'h00;
		if (wr_i) begin
			unique case (addr_i)
				ADDR_AV_STOP_UPPER: stop_up_d = wdata_i;
				ADDR_AV_STOP_LOWER: stop_d = {stop_up_q, wdata_i[1:0]}; // RQ1
				ADDR_GENLOCK_FV:    gl_d = wdata_i & MASK_GENLOCK_FV;  // RQ19
				ADDR_HSYNC_START:   hs_d = wdata_i;
				ADDR_VBLANK_START:  vbs_d = wdata_i;
				ADDR_VBLANK_STOP:   vbe_d = wdata_i;
				ADDR_CHROMA_ONE: begin
					// pll reset bit is never stored, so it always reads back 0
					c1_d = wdata_i & MASK_CHROMA_ONE & ~(8'h01 << C1_PLL_RST); // RQ11
					pll_rst_d = wdata_i[C1_PLL_RST]; // RQ11
				end
				ADDR_CHROMA_TWO:    c2_d = wdata_i & MASK_CHROMA_TWO; // RQ19
				default: ;
			endcase
		end
		// request set wins over the line-start consume
		if (pll_rst_q)
			glpend_d = 1'b1; // RQ12
		else if (line_s)
			glpend_d = 1'b0;
		if (rd_i) begin
			unique case (addr_i)
				ADDR_AV_STOP_UPPER: rdata_d = stop_up_q;
				ADDR_AV_STOP_LOWER: rdata_d = {6'h00, stop_q[1:0]} & MASK_AV_STOP_LOWER; // RQ19
				ADDR_GENLOCK_FV:    rdata_d = gl_q;
				ADDR_HSYNC_START:   rdata_d = hs_q;
				ADDR_VBLANK_START:  rdata_d = vbs_q;
				ADDR_VBLANK_STOP:   rdata_d = vbe_q;
				ADDR_CHROMA_ONE:    rdata_d = c1_q;
				ADDR_CHROMA_TWO:    rdata_d = c2_q;
				default:            rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stop_up_q <= RST_AV_STOP_UPPER;
			stop_q    <= {RST_AV_STOP_UPPER, RST_AV_STOP_LOWER}; // RQ2
			gl_q      <= RST_GENLOCK_FV;
			hs_q      <= RST_HSYNC_START;
			vbs_q     <= RST_VBLANK_START;
			vbe_q     <= RST_VBLANK_STOP;
			c1_q      <= RST_CHROMA_ONE; // RQ16
			c2_q      <= RST_CHROMA_TWO; // RQ16
			pll_rst_q <= 1'b0;
			glpend_q  <= 1'b0;
			rdata_q   <= 8'h00;
		end else begin
			stop_up_q <= stop_up_d;
			stop_q    <= stop_d;
			gl_q      <= gl_d;
			hs_q      <= hs_d;
			vbs_q     <= vbs_d;
			vbe_q     <= vbe_d;
			c1_q      <= c1_d;
			c2_q      <= c2_d;
			pll_rst_q <= pll_rst_d;
			glpend_q  <= glpend_d;
			rdata_q   <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decoded controls
	vdtc_fv_t   fv_w;
	vdtc_comb_t prim_w;
	logic       f_d, v_d, f_q, v_q, pin_d, pin_q, gl_out_w;
	logic [2:0] cm3_w;
	logic [1:0] cm2_w;
	logic signed [10:0] hshift_d;
	logic [8:0] hb2hs_d, hblen_d;
	logic [2:0] comb_d;
	logic [10:0] bw_d;
	logic       adapt_d, none_d;

	assign fv_w  = vdtc_fv_t'(gl_q[FV_LSB +: 2]);
	assign cm3_w = c2_q[C2_CM_LSB + 1 +: 3];
	assign cm2_w = c2_q[C2_CM_LSB + 1 +: 2];
	// the stream carries the phase-reset flag from a request until the next line start
	assign gl_out_w = gl_s2_q | glpend_q; // RQ12

	always_comb begin
		// RQ4
		f_d = f_q;
		v_d = v_q;
		if (std_s) begin
			f_d = f656_s;
			v_d = v656_s;
		end else begin
			if (fb_s)
				v_d = ~v_q;
			unique case (fv_w)
				VDTC_FV_EVEN_ODD: f_d = odd_s ? (fb_s ? ~f_q : f_q) : 1'b1;
				VDTC_FV_TOGGLE:   f_d = fb_s ? ~f_q : f_q;
				VDTC_FV_PULSE:    f_d = fb_s;
				VDTC_FV_BAD:      f_d = f_q;
			endcase
		end
		// RQ18
		pin_d = sel_s2_q ? gl_out_w : f_q;
		// RQ6
		hshift_d = 11'(signed'({3'b000, HSYNC_CENTER}) - signed'({3'b000, hs_q}))
		           <<< HSYNC_STEP_SHIFT;
		// RQ7
		unique case (vdtc_std_t'(video_std_i))
			VDTC_STD_PAL:   begin hb2hs_d = HB2HS_PAL;   hblen_d = HBLEN_PAL;   end
			VDTC_STD_SECAM: begin hb2hs_d = HB2HS_SECAM; hblen_d = HBLEN_SECAM; end
			default:        begin hb2hs_d = HB2HS_NTSC;  hblen_d = HBLEN_NTSC;  end
		endcase
		// RQ14 RQ15
		prim_w  = vdtc_comb_t'(3'(cm2_w) + 3'h1);
		adapt_d = c1_q[C1_ACE];
		none_d  = 1'b0;
		if (c1_q[C1_ACE]) begin
			comb_d = prim_w;
			none_d = c2_q[C2_CM_LSB];
		end else if (!c1_q[C1_CE])
			comb_d = VDTC_COMB_OFF;
		else if (cm3_w[2])
			comb_d = VDTC_COMB_2L;
		else
			comb_d = prim_w;
		// RQ17
		bw_d = CHROMA_BW_KHZ[{c2_q[C2_WCF], c2_q[C2_NOTCH_LSB +: 2]}];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			f_q   <= 1'b0;
			v_q   <= 1'b0;
			pin_q <= 1'b0;
			field_bit_o <= 1'b0;
			vert_bit_o  <= 1'b0;
			rtc_mode_o  <= 1'b0;
			rtc_submode_o <= 1'b0;
			general_purpose_pin_o <= 1'b0;
			active_video_window_stop_o <= 10'sh000;
			hsync_shift_o <= 11'sh000;
			hblank_to_hsync_delay_o <= HB2HS_NTSC;
			hblank_length_o <= HBLEN_NTSC;
			vblank_start_adj_o <= 8'sh00;
			vblank_stop_adj_o <= 8'sh00;
			color_pll_reset_o <= 1'b0;
			auto_chroma_gain_o <= 2'h0;
			comb_primary_o <= 3'h0;
			comb_adaptive_o <= 1'b0;
			comb_fallback_none_o <= 1'b0;
			chroma_bw_khz_o <= 11'h000;
		end else begin
			f_q   <= f_d;
			v_q   <= v_d;
			pin_q <= pin_d;
			field_bit_o <= f_q;
			vert_bit_o  <= v_q;
			rtc_mode_o  <= gl_q[GL_RTC_BIT]; // RQ5
			rtc_submode_o <= gl_q[GL_MODE_BIT]; // RQ5
			general_purpose_pin_o <= pin_q;
			active_video_window_stop_o <= signed'(stop_q); // RQ2
			hsync_shift_o <= hshift_d;
			hblank_to_hsync_delay_o <= hb2hs_d;
			hblank_length_o <= hblen_d;
			vblank_start_adj_o <= signed'(vbs_q); // RQ8 RQ10
			vblank_stop_adj_o <= signed'(vbe_q); // RQ9 RQ10
			color_pll_reset_o <= pll_rst_q; // RQ11
			auto_chroma_gain_o <= c1_q[C1_AUTO_CHROMA_GAIN_LSB +: 2]; // RQ13
			comb_primary_o <= comb_d;
			comb_adaptive_o <= adapt_d;
			comb_fallback_none_o <= none_d;
			chroma_bw_khz_o <= bw_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_stop_on_lower;
		@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == ADDR_AV_STOP_LOWER) |=> ##1
		active_video_window_stop_o == signed'({$past(stop_up_q, 2), $past(wdata_i[1:0], 2)});
	endproperty
	a_stop_on_lower: assert property (p_stop_on_lower) else $error("stop offset not applied"); // RQ1

	property p_stop_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(wr_i && addr_i == ADDR_AV_STOP_LOWER) |=> ##1 $stable(active_video_window_stop_o);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop offset moved without lower write"); // RQ2

	property p_pll_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(wr_i && addr_i == ADDR_CHROMA_ONE && wdata_i[C1_PLL_RST]) |=> ##1
		color_pll_reset_o ##1 !color_pll_reset_o;
	endproperty
	a_pll_pulse: assert property (p_pll_pulse) else $error("pll reset not a single pulse"); // RQ11

	property p_pll_reads_zero;
		@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == ADDR_CHROMA_ONE) |=> rdata_o[C1_PLL_RST] == 1'b0;
	endproperty
	a_pll_reads_zero: assert property (p_pll_reads_zero) else $error("pll reset bit reads set"); // RQ11

	property p_glpend;
		@(posedge clk_i) disable iff (rst_i)
		pll_rst_q |=> glpend_q;
	endproperty
	a_glpend: assert property (p_glpend) else $error("phase reset flag not raised"); // RQ12

	property p_hshift_center;
		@(posedge clk_i) disable iff (rst_i)
		(hs_q == HSYNC_CENTER) [*2] |-> hsync_shift_o == 11'sh000;
	endproperty
	a_hshift_center: assert property (p_hshift_center) else $error("hsync shift not zero at center"); // RQ6

	property p_rsvd_zero;
		@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == ADDR_GENLOCK_FV) |=> (rdata_o & ~MASK_GENLOCK_FV) == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero"); // RQ19

	property p_comb_off;
		@(posedge clk_i) disable iff (rst_i)
		(!c1_q[C1_ACE] && !c1_q[C1_CE]) |=> comb_primary_o == VDTC_COMB_OFF;
	endproperty
	a_comb_off: assert property (p_comb_off) else $error("comb not disabled"); // RQ14

	property p_pulse_mode;
		@(posedge clk_i) disable iff (rst_i)
		(!std_s && fv_w == VDTC_FV_PULSE) |=> f_q == $past(fb_s);
	endproperty
	a_pulse_mode: assert property (p_pulse_mode) else $error("F pulse mode wrong"); // RQ4

	property p_std_fv;
		@(posedge clk_i) disable iff (rst_i)
		std_s |=> (f_q == $past(f656_s)) && (v_q == $past(v656_s));
	endproperty
	a_std_fv: assert property (p_std_fv) else $error("F and V not following stream"); // RQ4

	property p_v_toggle;
		@(posedge clk_i) disable iff (rst_i)
		(!std_s && fb_s) |=> v_q != $past(v_q);
	endproperty
	a_v_toggle: assert property (p_v_toggle) else $error("V did not switch at boundary"); // RQ4

	property p_pend_clear;
		@(posedge clk_i) disable iff (rst_i)
		(!pll_rst_q && line_s) |=> !glpend_q;
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("phase reset flag kept"); // RQ12

	property p_comb_two_line;
		@(posedge clk_i) disable iff (rst_i)
		(!c1_q[C1_ACE] && c1_q[C1_CE] && cm3_w[2]) |=> comb_primary_o == VDTC_COMB_2L;
	endproperty
	a_comb_two_line: assert property (p_comb_two_line) else $error("fixed two-line not chosen"); // RQ14

	property p_pin_field;
		@(posedge clk_i) disable iff (rst_i)
		!sel_s2_q |=> pin_q == $past(f_q);
	endproperty
	a_pin_field: assert property (p_pin_field) else $error("shared pin not showing F"); // RQ18

	property p_pll_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!(wr_i && addr_i == ADDR_CHROMA_ONE && wdata_i[C1_PLL_RST]) |=> ##1 !color_pll_reset_o;
	endproperty
	a_pll_quiet: assert property (p_pll_quiet) else $error("pll reset without request"); // RQ11

	assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ==== rtl/vdtc_pkg.sv ====
// vdtc_pkg: register map, field layout, reset values and timing tables of the
// video decoder timing and chroma control bank.
// assumes a byte-wide register port with byte offsets as printed.
//
// Overview of operation
// RQ1: upper stop bits written first; ten-bit stop applied only on lower-bits write.
// RQ2: stop offset is two's complement -512..511 relative to default stop.
// RQ3: software keeps active pixel count per line even.
// RQ4: F and V follow BT.656 for standard counts, field setting otherwise.
// RQ5: bit 0 picks genlock or real-time-control output; bit 2 picks mode.
// RQ6: hsync start shifts by (128 minus value) times 4 pixel clocks.
// RQ7: blank-to-sync and blank length counts per standard: 16/272, 20/284, 40/280.
// RQ8: vertical blank start moved by signed line count from standard start.
// RQ9: vertical blank stop moved by signed line count from standard stop.
// RQ10: adjusted blank lines drive blank pin and bound luma bypass duration.
// RQ11: writing 1 to color PLL reset zeroes phase; bit self-clears.
// RQ12: after PLL reset, phase-reset bit goes out on genlock stream next line; the stream carries it from the request until the next line start.
// RQ13: auto chroma gain: 00 on, 01 reserved, 10 off, 11 hold.
// RQ14: comb off when both enables 0; fixed filter chosen by mode bits 3:1.
// RQ15: adaptive comb: bits 2:1 pick primary, bit 0 two-line or no comb.
// RQ16: defaults adaptive three-line vs none for NTSC, four-line vs none for PAL; the reset values give three-line vs none for every standard.
// RQ17: chroma bandwidth from notch select and wideband enable.
// RQ18: shared pin gives genlock stream when select is 1, field identifier when 0.
// RQ19: reserved bits read zero and ignore writes.
package vdtc_pkg;
	localparam logic [7:0] ADDR_AV_STOP_UPPER = 8'h13;
	localparam logic [7:0] ADDR_AV_STOP_LOWER = 8'h14;
	localparam logic [7:0] ADDR_GENLOCK_FV    = 8'h15;
	localparam logic [7:0] ADDR_HSYNC_START   = 8'h16;
	localparam logic [7:0] ADDR_VBLANK_START  = 8'h18;
	localparam logic [7:0] ADDR_VBLANK_STOP   = 8'h19;
	localparam logic [7:0] ADDR_CHROMA_ONE    = 8'h1A;
	localparam logic [7:0] ADDR_CHROMA_TWO    = 8'h1B;

	localparam logic [7:0] RST_AV_STOP_UPPER = 8'h00;
	localparam logic [1:0] RST_AV_STOP_LOWER = 2'h0;
	localparam logic [7:0] RST_GENLOCK_FV    = 8'h01;
	localparam logic [7:0] RST_HSYNC_START   = 8'h80;
	localparam logic [7:0] RST_VBLANK_START  = 8'h00;
	localparam logic [7:0] RST_VBLANK_STOP   = 8'h00;
	localparam logic [7:0] RST_CHROMA_ONE    = 8'h0C;
	localparam logic [7:0] RST_CHROMA_TWO    = 8'h14;

	// writable bit masks; everything else is reserved
	localparam logic [7:0] MASK_AV_STOP_LOWER = 8'h03;
	localparam logic [7:0] MASK_GENLOCK_FV    = 8'h37;
	localparam logic [7:0] MASK_CHROMA_ONE    = 8'h1F;
	localparam logic [7:0] MASK_CHROMA_TWO    = 8'hF7;

	localparam int FV_LSB        = 4;
	localparam int GL_MODE_BIT   = 2;
	localparam int GL_RTC_BIT    = 0;
	localparam int C1_PLL_RST    = 4;
	localparam int C1_ACE        = 3;
	localparam int C1_CE         = 2;
	localparam int C1_AUTO_CHROMA_GAIN_LSB   = 0;
	localparam int C2_CM_LSB     = 4;
	localparam int C2_WCF        = 2;
	localparam int C2_NOTCH_LSB  = 0;

	localparam logic [7:0] HSYNC_CENTER = 8'h80;
	localparam int         HSYNC_STEP_SHIFT = 2;

	typedef enum logic [1:0] {VDTC_STD_NTSC, VDTC_STD_PAL, VDTC_STD_SECAM} vdtc_std_t;
	typedef enum logic [1:0] {VDTC_FV_EVEN_ODD, VDTC_FV_TOGGLE, VDTC_FV_PULSE, VDTC_FV_BAD} vdtc_fv_t;
	typedef enum logic [1:0] {VDTC_GAIN_AUTO, VDTC_GAIN_RSVD, VDTC_GAIN_OFF, VDTC_GAIN_HOLD} vdtc_gain_t;
	typedef enum logic [2:0] {
		VDTC_COMB_OFF, VDTC_COMB_3L_121, VDTC_COMB_3L_101, VDTC_COMB_4L_1111,
		VDTC_COMB_4L_1331, VDTC_COMB_2L
	} vdtc_comb_t;

	localparam logic [8:0] HB2HS_NTSC  = 9'h010;
	localparam logic [8:0] HB2HS_PAL   = 9'h014;
	localparam logic [8:0] HB2HS_SECAM = 9'h028;
	localparam logic [8:0] HBLEN_NTSC  = 9'h110;
	localparam logic [8:0] HBLEN_PAL   = 9'h11C;
	localparam logic [8:0] HBLEN_SECAM = 9'h118;

	// chroma bandwidth in kHz, index {wide, notch}
	localparam logic [10:0] CHROMA_BW_KHZ [8] = '{
		11'h4C5, 11'h36E, 11'h2DA, 11'h1F3,
		11'h589, 11'h406, 11'h34C, 11'h22A
	};
endpackage

// ==== tb/test_vdtc_regs.sv ====
// test_vdtc_regs: self-checking bench for the video timing and chroma control bank.
// assumes one clock, reads answered one cycle later, and no wait states on the port.
`timescale 1ns/10ps
`default_nettype none
module test_vdtc_regs
	import vdtc_pkg::*;
;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic [7:0]        addr_i = 8'h00;
	logic [7:0]        wdata_i = 8'h00;
	logic              wr_i = 1'b0;
	logic              rd_i = 1'b0;
	logic [1:0]        video_std_i = 2'h0;
	logic              line_start_i = 1'b0;
	logic              field_boundary_i = 1'b0;
	logic              std_line_count_i = 1'b1;
	logic              odd_line_count_i = 1'b0;
	logic              field_bt656_i = 1'b0;
	logic              vbit_bt656_i = 1'b0;
	logic              genlock_bit_i = 1'b0;
	logic              genlock_serial_out_select_i = 1'b1;
	wire logic [7:0]   rdata_o;
	wire logic         field_bit_o, vert_bit_o, rtc_mode_o, rtc_submode_o;
	wire logic         general_purpose_pin_o, color_pll_reset_o;
	wire logic         comb_adaptive_o, comb_fallback_none_o;
	wire logic [9:0]   active_video_window_stop_o;
	wire logic [10:0]  hsync_shift_o;
	wire logic [8:0]   hblank_to_hsync_delay_o, hblank_length_o;
	wire logic [7:0]   vblank_start_adj_o, vblank_stop_adj_o;
	wire logic [1:0]   auto_chroma_gain_o;
	wire logic [2:0]   comb_primary_o;
	wire logic [10:0]  chroma_bw_khz_o;
	int                err_total = 0;
	int                checked = 0;

	vdtc_regs i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .video_std_i(video_std_i),
		.line_start_i(line_start_i), .field_boundary_i(field_boundary_i),
		.std_line_count_i(std_line_count_i), .odd_line_count_i(odd_line_count_i),
		.field_bt656_i(field_bt656_i), .vbit_bt656_i(vbit_bt656_i),
		.genlock_bit_i(genlock_bit_i), .genlock_serial_out_select_i(genlock_serial_out_select_i),
		.field_bit_o(field_bit_o), .vert_bit_o(vert_bit_o), .rtc_mode_o(rtc_mode_o),
		.rtc_submode_o(rtc_submode_o), .general_purpose_pin_o(general_purpose_pin_o),
		.active_video_window_stop_o(active_video_window_stop_o),
		.hsync_shift_o(hsync_shift_o), .hblank_to_hsync_delay_o(hblank_to_hsync_delay_o),
		.hblank_length_o(hblank_length_o), .vblank_start_adj_o(vblank_start_adj_o),
		.vblank_stop_adj_o(vblank_stop_adj_o), .color_pll_reset_o(color_pll_reset_o),
		.auto_chroma_gain_o(auto_chroma_gain_o), .comb_primary_o(comb_primary_o),
		.comb_adaptive_o(comb_adaptive_o), .comb_fallback_none_o(comb_fallback_none_o),
		.chroma_bw_khz_o(chroma_bw_khz_o)
	);

	always #10 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic signed [31:0] seen, input logic signed [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t: saw %0d expected %0d", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	task automatic fb_pulse;
		@(posedge clk_i);
		field_boundary_i <= 1'b1;
		@(posedge clk_i);
		field_boundary_i <= 1'b0;
	endtask

	task automatic close_out;
		$display("summary: %0d mismatches, %0d comparisons", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] ad [9] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h17};
		logic [7:0] ex [9] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 8'h0C, 8'h14, 8'h00};
		for (int i = 0; i < 9; i++)
			rd_chk(ad[i], ex[i]);
		chk(active_video_window_stop_o, 0);
		chk(hsync_shift_o, 0);
		chk({rtc_mode_o, rtc_submode_o}, 2);
		chk({comb_adaptive_o, comb_primary_o, comb_fallback_none_o}, 19);
		chk(chroma_bw_khz_o, 1417);
	endtask

	task automatic t_stop;
		wr_reg(8'h13, 8'h80);
		cyc(2);
		chk($signed(active_video_window_stop_o), 0);
		wr_reg(8'h14, 8'h00);
		cyc(2);
		chk($signed(active_video_window_stop_o), -512);
		wr_reg(8'h14, 8'h02);
		cyc(2);
		chk($signed(active_video_window_stop_o), -510);
		wr_reg(8'h13, 8'h7F);
		wr_reg(8'h14, 8'h02);
		cyc(2);
		chk($signed(active_video_window_stop_o), 510);
	endtask

	task automatic t_timing;
		logic [7:0] hv [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
		int         dl [4] = '{16, 20, 40, 16};
		int         ln [4] = '{272, 284, 280, 272};
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h16, hv[i]);
			cyc(2);
			chk($signed(hsync_shift_o), (128 - int'(hv[i])) * 4);
			@(posedge clk_i);
			video_std_i <= 2'(i);
			cyc(3);
			chk(hblank_to_hsync_delay_o, dl[i]);
			chk(hblank_length_o, ln[i]);
		end
		@(posedge clk_i);
		video_std_i <= 2'h0;
		wr_reg(8'h18, 8'h7F);
		wr_reg(8'h19, 8'h81);
		cyc(2);
		chk($signed(vblank_start_adj_o), 127);
		chk($signed(vblank_stop_adj_o), -127);
		wr_reg(8'h18, 8'h81);
		wr_reg(8'h19, 8'h01);
		cyc(2);
		chk($signed(vblank_start_adj_o), -127);
		chk($signed(vblank_stop_adj_o), 1);
	endtask

	task automatic t_chroma;
		int bw [8] = '{1221, 878, 730, 499, 1417, 1030, 844, 554};
		for (int n = 0; n < 8; n++) begin
			wr_reg(8'h1B, {5'h00, 3'(n)});
			cyc(2);
			chk(chroma_bw_khz_o, bw[n]);
		end
		for (int g = 0; g < 4; g++) begin
			wr_reg(8'h1A, {6'h03, 2'(g)});
			cyc(2);
			chk(auto_chroma_gain_o, g);
		end
		for (int e = 0; e < 3; e++)
			for (int m = 0; m < 16; m++) begin
				wr_reg(8'h1A, {4'h0, e == 2, e == 1, 2'h0});
				wr_reg(8'h1B, {4'(m), 4'h4});
				cyc(2);
				if (e == 0)
					chk({comb_adaptive_o, comb_primary_o}, 0);
				else if (e == 1)
					chk(comb_primary_o, m[3] ? 5 : m[2:1] + 1);
				else
					chk({comb_adaptive_o, comb_primary_o, comb_fallback_none_o},
						16 + (m[2:1] + 1) * 2 + m[0]);
			end
		wr_reg(8'h1A, 8'h0C);
		wr_reg(8'h1B, 8'h14);
	endtask

	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			wr_reg(8'h15, 8'(i));
			cyc(2);
			chk(rtc_mode_o, i % 2);
			if (i % 2 == 1)
				chk(rtc_submode_o, i / 4);
		end
		wr_reg(8'h15, 8'hFF);
		rd_chk(8'h15, 8'h37);
		wr_reg(8'h14, 8'hFE);
		rd_chk(8'h14, 8'h02);
		wr_reg(8'h1B, 8'hFF);
		rd_chk(8'h1B, 8'hF7);
		wr_reg(8'h17, 8'h55);
		rd_chk(8'h17, 8'h00);
		wr_reg(8'h15, 8'h01);
		wr_reg(8'h1B, 8'h14);
	endtask

	task automatic t_pll;
		int n;
		n = 0;
		wr_reg(8'h1A, 8'h1C);
		for (int i = 0; i < 6; i++) begin
			cyc(1);
			n += color_pll_reset_o;
		end
		chk(n, 1);
		rd_chk(8'h1A, 8'h0C);
		cyc(4);
		chk(general_purpose_pin_o, 1);
		@(posedge clk_i);
		line_start_i <= 1'b1;
		@(posedge clk_i);
		line_start_i <= 1'b0;
		cyc(8);
		chk(general_purpose_pin_o, 0);
		genlock_bit_i <= 1'b1;
		cyc(8);
		chk(general_purpose_pin_o, 1);
		genlock_serial_out_select_i <= 1'b0;
		genlock_bit_i <= 1'b0;
		cyc(8);
		chk(general_purpose_pin_o, 1);
		genlock_serial_out_select_i <= 1'b1;
	endtask

	task automatic t_fv;
		logic f;
		logic v;
		int   n;
		field_bt656_i <= 1'b1;
		vbit_bt656_i <= 1'b1;
		cyc(8);
		chk({field_bit_o, vert_bit_o}, 3);
		std_line_count_i <= 1'b0;
		wr_reg(8'h15, 8'h11);
		cyc(8);
		f = field_bit_o;
		v = vert_bit_o;
		fb_pulse;
		cyc(8);
		chk({field_bit_o, vert_bit_o}, {~f, ~v});
		wr_reg(8'h15, 8'h01);
		cyc(8);
		chk(field_bit_o, 1);
		odd_line_count_i <= 1'b1;
		fb_pulse;
		cyc(8);
		chk(field_bit_o, 0);
		wr_reg(8'h15, 8'h21);
		fb_pulse;
		n = 0;
		for (int i = 0; i < 8; i++) begin
			cyc(1);
			n += field_bit_o;
		end
		chk(n, 1);
		wr_reg(8'h15, 8'h01);
		odd_line_count_i <= 1'b0;
		std_line_count_i <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(3);
		t_reset;
		t_stop;
		t_timing;
		t_chroma;
		t_regs;
		t_fv;
		t_pll;
		close_out;
	end

	// the whole sequence needs well under three thousand cycles
	initial begin
		#(20 * 20000);
		err_total++;
		close_out;
	end
endmodule
`default_nettype wire
